/* link_diag_pkg.sv */
// Constants shared by the link diagnostic register bank
package link_diag_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_PAGE_SELECT   = 6'h13;
  localparam logic [5:0] IDX_CABLE_LENGTH  = 6'h14;
  localparam logic [5:0] IDX_OFFSET_RESULT   = 6'h15;
  localparam logic [5:0] IDX_SIGNAL_DETECT = 6'h1E;

  // ----------------------------------------------------------------
  // Page values
  // ----------------------------------------------------------------
  localparam logic [2:0] PAGE_TEST         = 3'h1;
  localparam logic [2:0] PAGE_DIAG         = 3'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SD_FIXED_ONE_BIT  = 15;
  localparam int SD_FAST_LOSS_BIT  = 8;
  localparam int FQ_SAMPLE_BIT     = 15;
  localparam int FQ_SELECT_BIT     = 8;
  localparam int PAGE_MSB          = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] PAGE_RESET        = 3'h0;
  localparam logic [7:0] SPAN_RESET        = 8'hFF;
  localparam logic [7:0] SPAN_UNKNOWN      = 8'hFF;
  localparam logic [7:0] RESULT_RESET      = 8'h00;
  localparam logic       FAST_LOSS_RESET   = 1'b0;
  localparam logic       SELECT_RESET      = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int FAST_LOSS_NS      = 1;
  localparam int FAST_LOSS_US      = 1;
  localparam int SLOW_LOSS_US      = 250;
  localparam int FAST_LOSS_CYCLES  = (FAST_LOSS_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLOW_LOSS_CYCLES  = (SLOW_LOSS_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Fetch sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_WAIT = 2'b01,
    FETCH_LOAD = 2'b11
  } fetch_state_e;

endpackage

/* sd_loss_timer.sv */
// Times a continuous absence of signal detect and flags link loss
`timescale 1ns/1ps
`default_nettype none
module sd_loss_timer #(
  parameter int FAST_CYCLES = 250,
  parameter int SLOW_CYCLES = 62500,
  parameter int CW          = 17
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Control and status
  input  wire logic signal_present,
  input  wire logic fast_loss_select,
  output logic      link_loss
);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_link_loss;
  logic [CW-1:0] limit;

  assign limit = fast_loss_select ? CW'(FAST_CYCLES) : CW'(SLOW_CYCLES);

  // ----------------------------------------------------------------
  // Absence counter
  // ----------------------------------------------------------------
  always_comb begin
    next_count     = count;
    next_link_loss = link_loss;
    if (signal_present) begin
      next_count     = '0;
      next_link_loss = 1'b0;
    end else if (count >= limit) begin
      next_link_loss = 1'b1;
    end else begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count     <= '0;
      link_loss <= 1'b0;
    end else begin
      count     <= next_count;
      link_loss <= next_link_loss;
    end
  end

endmodule
`default_nettype wire

/* link_diag_status_regs.sv */
// Link diagnostic and signal detect register bank behind an APB slave
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module link_diag_status_regs #(
  parameter int SLOW_LOSS_CYCLES = link_diag_pkg::SLOW_LOSS_CYCLES
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Signal detect path
  input  wire logic        SIGNAL_DETECT,
  output logic             LINK_LOSS,
  output logic             FAST_LOSS_SELECT,
  // Cable length estimator
  input  wire logic [7:0]  SPAN_ESTIMATE,
  input  wire logic        SPAN_DETERMINED,
  input  wire logic        SPEED_100,
  input  wire logic        LINK_VALID,
  // DSP frequency fetch
  output logic             DSP_FETCH_REQ,
  input  wire logic        DSP_FETCH_ACK,
  input  wire logic [7:0]  DSP_LONG_OFFSET,
  input  wire logic [7:0]  DSP_PHASE_CORR,
  // Current page
  output logic [2:0]       PAGE
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                       sd_s1;
  logic                       sd_s2;
  logic                       sd_s3;
  logic                       sd_level;
  logic                       next_sd_level;
  logic [2:0]                 page_select_register;
  logic [2:0]                 next_page;
  logic                       fast_loss_select;
  logic                       next_fast_loss;
  logic                       value_select;
  logic                       next_value_select;
  logic                       fetch_select;
  logic                       next_fetch_select;
  logic [7:0]                 wire_span_estimate;
  logic [7:0]                 next_span;
  logic [7:0]                 offset_result;
  logic [7:0]                 next_result;
  logic [31:0]                next_prdata;
  link_diag_pkg::fetch_state_e fetch_state;
  link_diag_pkg::fetch_state_e next_fetch_state;
  logic [7:0]                 fetched;
  logic [7:0]                 next_fetched;
  logic [5:0]                 index;
  logic                       aligned;
  logic                       hit_page;
  logic                       hit_span;
  logic                       hit_offset;
  logic                       hit_config;
  logic                       mapped;
  logic                       setup;
  logic                       wr_access;
  logic                       offset_sample_request;
  logic [8:0]                 control_sum;
  logic [7:0]                 control_value;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign index      = PADDR[7:2];
  assign aligned    = PADDR[1:0] == 2'b00;
  assign hit_page   = aligned && index == link_diag_pkg::IDX_PAGE_SELECT;
  assign hit_span   = aligned && index == link_diag_pkg::IDX_CABLE_LENGTH
                      && page_select_register == link_diag_pkg::PAGE_DIAG;
  assign hit_offset = aligned && index == link_diag_pkg::IDX_OFFSET_RESULT
                      && page_select_register == link_diag_pkg::PAGE_DIAG;
  assign hit_config = aligned && index == link_diag_pkg::IDX_SIGNAL_DETECT
                      && page_select_register == link_diag_pkg::PAGE_TEST;
  assign mapped     = hit_page || hit_span || hit_offset || hit_config;
  assign setup      = PSEL && !PENABLE;
  assign wr_access  = PSEL && PENABLE && PWRITE && mapped;

  // Zero wait states; unmapped or wrong-page access answers with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  assign offset_sample_request = wr_access && hit_offset && PWDATA[link_diag_pkg::FQ_SAMPLE_BIT];

  // ----------------------------------------------------------------
  // Signal detect synchroniser
  // ----------------------------------------------------------------
  always_comb begin
    next_sd_level = sd_level;
    if (sd_s2 == sd_s3) begin
      next_sd_level = sd_s3;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sd_s1    <= 1'b0;
      sd_s2    <= 1'b0;
      sd_s3    <= 1'b0;
      sd_level <= 1'b0;
    end else begin
      sd_s1    <= SIGNAL_DETECT;
      sd_s2    <= sd_s1;
      sd_s3    <= sd_s2;
      sd_level <= next_sd_level;
    end
  end

  sd_loss_timer #(
    .FAST_CYCLES (link_diag_pkg::FAST_LOSS_CYCLES),
    .SLOW_CYCLES (SLOW_LOSS_CYCLES),
    .CW          (32)
  ) u_loss_timer (
    .clk              (REF_CLK),
    .srst             (SRST),
    .signal_present   (sd_level),
    .fast_loss_select (fast_loss_select),
    .link_loss        (LINK_LOSS)
  );

  // ----------------------------------------------------------------
  // Software-written control
  // ----------------------------------------------------------------
  always_comb begin
    next_page         = page_select_register;
    next_fast_loss    = fast_loss_select;
    next_value_select = value_select;
    if (wr_access && hit_page) begin
      next_page = PWDATA[link_diag_pkg::PAGE_MSB:0];
    end
    if (wr_access && hit_config) begin
      next_fast_loss = PWDATA[link_diag_pkg::SD_FAST_LOSS_BIT];
    end
    if (wr_access && hit_offset) begin
      next_value_select = PWDATA[link_diag_pkg::FQ_SELECT_BIT];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      page_select_register <= link_diag_pkg::PAGE_RESET;
      fast_loss_select     <= link_diag_pkg::FAST_LOSS_RESET;
      value_select         <= link_diag_pkg::SELECT_RESET;
    end else begin
      page_select_register <= next_page;
      fast_loss_select     <= next_fast_loss;
      value_select         <= next_value_select;
    end
  end

  assign PAGE             = page_select_register;
  assign FAST_LOSS_SELECT = fast_loss_select;

  // ----------------------------------------------------------------
  // Cable span estimate
  // ----------------------------------------------------------------
  always_comb begin
    next_span = link_diag_pkg::SPAN_UNKNOWN;
    if (SPEED_100 && LINK_VALID && SPAN_DETERMINED) begin
      next_span = SPAN_ESTIMATE;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      wire_span_estimate <= link_diag_pkg::SPAN_RESET;
    end else begin
      wire_span_estimate <= next_span;
    end
  end

  // ----------------------------------------------------------------
  // DSP fetch sequencer
  // ----------------------------------------------------------------
  // Control value saturates so the sum stays a valid signed byte
  assign control_sum   = {DSP_LONG_OFFSET[7], DSP_LONG_OFFSET} + {DSP_PHASE_CORR[7], DSP_PHASE_CORR};
  assign control_value = (control_sum[8] != control_sum[7]) ? {control_sum[8], {7{~control_sum[8]}}}
                                                            : control_sum[7:0];

  always_comb begin
    next_fetch_state  = fetch_state;
    next_fetch_select = fetch_select;
    next_fetched      = fetched;
    next_result       = offset_result;
    case (fetch_state)
      link_diag_pkg::FETCH_IDLE: begin
        if (offset_sample_request) begin
          next_fetch_select = PWDATA[link_diag_pkg::FQ_SELECT_BIT];
          next_fetch_state  = link_diag_pkg::FETCH_WAIT;
        end
      end
      link_diag_pkg::FETCH_WAIT: begin
        if (DSP_FETCH_ACK) begin
          next_fetched     = fetch_select ? control_value : DSP_LONG_OFFSET;
          next_fetch_state = link_diag_pkg::FETCH_LOAD;
        end
      end
      link_diag_pkg::FETCH_LOAD: begin
        next_result      = fetched;
        next_fetch_state = link_diag_pkg::FETCH_IDLE;
      end
      default: begin
        next_fetch_state = link_diag_pkg::FETCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      fetch_state   <= link_diag_pkg::FETCH_IDLE;
      fetch_select  <= link_diag_pkg::SELECT_RESET;
      fetched       <= link_diag_pkg::RESULT_RESET;
      offset_result <= link_diag_pkg::RESULT_RESET;
    end else begin
      fetch_state   <= next_fetch_state;
      fetch_select  <= next_fetch_select;
      fetched       <= next_fetched;
      offset_result <= next_result;
    end
  end

  assign DSP_FETCH_REQ = fetch_state == link_diag_pkg::FETCH_WAIT;

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata = PRDATA;
    if (setup) begin
      next_prdata = 32'h0000_0000;
      if (hit_page) begin
        next_prdata[link_diag_pkg::PAGE_MSB:0] = page_select_register;
      end
      if (hit_span) begin
        next_prdata[7:0] = wire_span_estimate;
      end
      if (hit_offset) begin
        next_prdata[link_diag_pkg::FQ_SELECT_BIT] = value_select;
        next_prdata[7:0]                          = offset_result;
      end
      if (hit_config) begin
        next_prdata[link_diag_pkg::SD_FIXED_ONE_BIT] = 1'b1;
        next_prdata[link_diag_pkg::SD_FAST_LOSS_BIT] = fast_loss_select;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
    end else begin
      PRDATA <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SAMPLE_READS_ZERO: assert property (@(posedge REF_CLK) disable iff (SRST)
    PSEL && PENABLE && hit_offset |-> !PRDATA[link_diag_pkg::FQ_SAMPLE_BIT] && PRDATA[14:9] == 6'h00)
    else $error("sample request bit or reserved bits read nonzero");

  AST_CONFIG_FIXED_BITS: assert property (@(posedge REF_CLK) disable iff (SRST)
    PSEL && PENABLE && hit_config |-> PRDATA[15:9] == 7'h40 && PRDATA[7:0] == 8'h00)
    else $error("config reserved bits read wrong");

  AST_PAGE_GATING: assert property (@(posedge REF_CLK) disable iff (SRST)
    PSEL && PENABLE && aligned && (index == link_diag_pkg::IDX_CABLE_LENGTH)
    && page_select_register != link_diag_pkg::PAGE_DIAG |-> PSLVERR)
    else $error("diagnostics register reached off its page");

  AST_SPAN_UNKNOWN: assert property (@(posedge REF_CLK) disable iff (SRST)
    !(SPEED_100 && LINK_VALID && SPAN_DETERMINED) |=> wire_span_estimate == 8'hFF)
    else $error("span not FFh while undetermined");

  AST_SPAN_FOLLOWS: assert property (@(posedge REF_CLK) disable iff (SRST)
    SPEED_100 && LINK_VALID && SPAN_DETERMINED |=> wire_span_estimate == $past(SPAN_ESTIMATE))
    else $error("span does not follow estimator");

  AST_REQUEST_STARTS: assert property (@(posedge REF_CLK) disable iff (SRST)
    offset_sample_request && fetch_state == link_diag_pkg::FETCH_IDLE |=> DSP_FETCH_REQ)
    else $error("sample request did not start a fetch");

  AST_RESULT_LOADS: assert property (@(posedge REF_CLK) disable iff (SRST)
    DSP_FETCH_REQ && DSP_FETCH_ACK && !fetch_select |=> ##1 offset_result == $past(DSP_LONG_OFFSET, 2))
    else $error("long-term offset not loaded two cycles after ack");

  AST_RESULT_HOLDS: assert property (@(posedge REF_CLK) disable iff (SRST)
    fetch_state != link_diag_pkg::FETCH_LOAD |=> $stable(offset_result))
    else $error("result changed without a completed fetch");

  AST_FAST_LOSS_WRITE: assert property (@(posedge REF_CLK) disable iff (SRST)
    wr_access && hit_config |=> fast_loss_select == $past(PWDATA[link_diag_pkg::SD_FAST_LOSS_BIT]))
    else $error("fast-loss select not written");

  AST_LOSS_CLEARS: assert property (@(posedge REF_CLK) disable iff (SRST)
    sd_level |=> !LINK_LOSS)
    else $error("link loss flag set while signal present");

  AST_LOSS_NEEDS_ABSENCE: assert property (@(posedge REF_CLK) disable iff (SRST)
    $rose(LINK_LOSS) |-> !$past(sd_level) && !$past(sd_level, 2))
    else $error("link loss flagged without absent signal");

  AST_SPAN_RESERVED: assert property (@(posedge REF_CLK) disable iff (SRST)
    PSEL && PENABLE && hit_span |-> PRDATA[15:8] == 8'h00)
    else $error("span reserved bits read nonzero");

  AST_ACK_ENDS_REQUEST: assert property (@(posedge REF_CLK) disable iff (SRST)
    DSP_FETCH_REQ && DSP_FETCH_ACK |=> !DSP_FETCH_REQ)
    else $error("fetch request stands after acknowledge");

  AST_OFF_PAGE_READS_ZERO: assert property (@(posedge REF_CLK) disable iff (SRST)
    PSEL && PENABLE && !mapped |-> PRDATA == 32'h0000_0000)
    else $error("refused access returned nonzero data");

endmodule
`default_nettype wire

/* link_diag_status_regs_tb.sv */
// Self-checking testbench for the link diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module link_diag_status_regs_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int SLOW = 40;
  localparam int FAST = 250;
  typedef struct packed {
    logic        rd;
    logic        err;
    logic [31:0] data;
  } note_s;
  logic        REF_CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        SIGNAL_DETECT, LINK_LOSS, FAST_LOSS_SELECT;
  logic [7:0]  SPAN_ESTIMATE;
  logic        SPAN_DETERMINED, SPEED_100, LINK_VALID;
  logic        DSP_FETCH_REQ, DSP_FETCH_ACK;
  logic [7:0]  DSP_LONG_OFFSET, DSP_PHASE_CORR;
  logic [2:0]  PAGE;
  note_s       notes[$];
  note_s       cur;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'h0000320C;
  logic [7:0]  last = 8'h00;

  link_diag_status_regs #(.SLOW_LOSS_CYCLES(SLOW)) u_link_diag_status_regs (
    .REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SIGNAL_DETECT(SIGNAL_DETECT), .LINK_LOSS(LINK_LOSS), .FAST_LOSS_SELECT(FAST_LOSS_SELECT),
    .SPAN_ESTIMATE(SPAN_ESTIMATE), .SPAN_DETERMINED(SPAN_DETERMINED), .SPEED_100(SPEED_100),
    .LINK_VALID(LINK_VALID), .DSP_FETCH_REQ(DSP_FETCH_REQ), .DSP_FETCH_ACK(DSP_FETCH_ACK),
    .DSP_LONG_OFFSET(DSP_LONG_OFFSET), .DSP_PHASE_CORR(DSP_PHASE_CORR), .PAGE(PAGE)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Signed sum clamped to the 8-bit result range
  function automatic logic [7:0] sat(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    if (s[8] != s[7]) return s[8] ? 8'h80 : 8'h7F;
    return s[7:0];
  endfunction

  task automatic report_and_stop();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // One APB transfer; the expected answer is queued for the monitor
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [15:0] wd,
                     input logic err, input logic [15:0] exp_data);
    int n;
    n = 0;
    notes.push_back('{rd: !wr, err: err, data: {16'h0000, exp_data}});
    PSEL <= 1'h1;
    PWRITE <= wr;
    PADDR <= addr;
    PWDATA <= {16'h0000, wd};
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'h1 && n < 50);
    if (n >= 50) chk(1'h0, "no ready");
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge REF_CLK);
  endtask

  // Drop signal detect and time the link loss flag
  task automatic loss(input int lim);
    int n;
    n = 0;
    SIGNAL_DETECT <= 1'h0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (LINK_LOSS !== 1'h1 && n < lim + 20);
    chk(n > lim && n <= lim + 10, "loss detect time");
    SIGNAL_DETECT <= 1'h1;
    repeat (8) @(posedge REF_CLK);
    chk(LINK_LOSS === 1'h0, "loss flag stuck");
  endtask

  // Sample request with the bench acting as the DSP
  task automatic fetch(input logic sel, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] e;
    int         n;
    e = sel ? sat(a, b) : a;
    n = 0;
    apb(1'h1, 8'h54, {1'h1, 6'h00, sel, 8'h00}, 1'h0, 16'h0000);
    while (DSP_FETCH_REQ !== 1'h1 && n < 20) begin
      @(posedge REF_CLK);
      n++;
    end
    chk(DSP_FETCH_REQ === 1'h1, "fetch not requested");
    apb(1'h0, 8'h54, 16'h0000, 1'h0, {7'h00, sel, last});
    repeat (xs() % 4) @(posedge REF_CLK);
    DSP_LONG_OFFSET <= a;
    DSP_PHASE_CORR <= b;
    DSP_FETCH_ACK <= 1'h1;
    @(posedge REF_CLK);
    DSP_FETCH_ACK <= 1'h0;
    repeat (3) @(posedge REF_CLK);
    DSP_LONG_OFFSET <= ~a;
    DSP_PHASE_CORR <= ~b;
    apb(1'h0, 8'h54, 16'h0000, 1'h0, {7'h00, sel, e});
    last = e;
  endtask

  // ----------------------------------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    REF_CLK = 1'h0;
    forever #2 REF_CLK = ~REF_CLK;
  end

  always @(posedge REF_CLK) begin
    if (PSEL === 1'h1 && PENABLE === 1'h1 && PREADY === 1'h1) begin
      if (notes.size() == 0) begin
        chk(1'h0, "unexpected transfer");
      end else begin
        cur = notes.pop_front();
        chk(PSLVERR === cur.err, "error response");
        if (cur.rd) chk(PRDATA === cur.data, "read data");
      end
    end
  end

  initial begin
    repeat (20000) @(posedge REF_CLK);
    chk(1'h0, "timeout");
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    SRST = 1'h1;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 8'h00;
    PWDATA = 32'h00000000;
    SIGNAL_DETECT = 1'h1;
    SPAN_ESTIMATE = 8'h00;
    SPAN_DETERMINED = 1'h0;
    SPEED_100 = 1'h0;
    LINK_VALID = 1'h0;
    DSP_FETCH_ACK = 1'h0;
    DSP_LONG_OFFSET = 8'h00;
    DSP_PHASE_CORR = 8'h00;
    repeat (16) @(posedge REF_CLK);
    SRST <= 1'h0;
    @(posedge REF_CLK);
    chk(LINK_LOSS === 1'h0 && FAST_LOSS_SELECT === 1'h0 && DSP_FETCH_REQ === 1'h0, "reset outputs");
    apb(1'h0, 8'h4C, 16'h0000, 1'h0, 16'h0000);
    apb(1'h0, 8'h78, 16'h0000, 1'h1, 16'h0000);
    apb(1'h0, 8'h50, 16'h0000, 1'h1, 16'h0000);
    apb(1'h1, 8'h4C, 16'h0001, 1'h0, 16'h0000);
    apb(1'h0, 8'h78, 16'h0000, 1'h0, 16'h8000);
    apb(1'h1, 8'h78, 16'h8900, 1'h0, 16'h0000);
    apb(1'h0, 8'h78, 16'h0000, 1'h0, 16'h8100);
    chk(FAST_LOSS_SELECT === 1'h1, "fast select");
    loss(FAST);
    apb(1'h1, 8'h78, 16'h8000, 1'h0, 16'h0000);
    loss(SLOW);
    apb(1'h0, 8'h54, 16'h0000, 1'h1, 16'h0000);
    apb(1'h1, 8'h4C, 16'h0002, 1'h0, 16'h0000);
    chk(PAGE === 3'h2, "page copy");
    apb(1'h0, 8'h78, 16'h0000, 1'h1, 16'h0000);
    apb(1'h0, 8'h50, 16'h0000, 1'h0, 16'h00FF);
    for (int i = 0; i < 4; i++) begin
      SPAN_ESTIMATE <= xs() % 8'hFF;
      SPEED_100 <= (i != 1);
      LINK_VALID <= (i != 2);
      SPAN_DETERMINED <= (i != 3);
      @(posedge REF_CLK);
      apb(1'h1, 8'h50, 16'hFFFF, 1'h0, 16'h0000);
      apb(1'h0, 8'h50, 16'h0000, 1'h0, (i == 0) ? {8'h00, SPAN_ESTIMATE} : 16'h00FF);
    end
    apb(1'h0, 8'h54, 16'h0000, 1'h0, 16'h0000);
    apb(1'h1, 8'h54, 16'h7E00, 1'h0, 16'h0000);
    apb(1'h0, 8'h54, 16'h0000, 1'h0, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      fetch(k[0], (k == 1) ? 8'h70 : (k == 3) ? 8'h90 : xs() % 9'h100,
            (k == 1) ? 8'h20 : (k == 3) ? 8'hE0 : xs() % 9'h100);
    end
    SRST <= 1'h1;
    repeat (3) @(posedge REF_CLK);
    SRST <= 1'h0;
    @(posedge REF_CLK);
    chk(PAGE === 3'h0 && DSP_FETCH_REQ === 1'h0 && LINK_LOSS === 1'h0, "mid-run reset");
    apb(1'h1, 8'h4C, 16'h0002, 1'h0, 16'h0000);
    apb(1'h0, 8'h54, 16'h0000, 1'h0, 16'h0000);
    apb(1'h1, 8'h4C, 16'h0003, 1'h0, 16'h0000);
    apb(1'h0, 8'h54, 16'h0000, 1'h1, 16'h0000);
    apb(1'h0, 8'h00, 16'h0000, 1'h1, 16'h0000);
    apb(1'h0, 8'h79, 16'h0000, 1'h1, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
